// ---- src/tbd_defs.svh ----
/*
 Constants of the trace bucket detector: register offsets, field positions,
 reset values. Assumes inclusion by bare name from the design files.
*/
// Behaviour
// - Normal rise-fall even bucket: minimum out, keep maximum
// - Normal rise-fall odd bucket: larger of maxima
// - Normal monotonic bucket: maximum out
// - Sample mode keeps one sample per bucket
// - Average mode uses every bucket sample
// - Averaging type: power, voltage, log or low-pass filtered
// - Power averaging outputs root mean square
// - Voltage averaging outputs mean linear voltage
// - Log averaging outputs mean decibel sample
// - Interference averaging through narrow low-pass
// - Weighted peak drops at slower repetition
// - Sample taken at bucket centre
// - Positive peak outputs bucket maximum
// - Negative peak outputs bucket minimum
// - Bucket width is span over points minus one
`ifndef TBD_DEFS_SVH
`define TBD_DEFS_SVH
// ==========================================================
// Register map (byte offsets)
`define TBD_CTRL_OFS 8'h00
`define TBD_BUCKET_OFS 8'h04
`define TBD_POINTS_OFS 8'h08
`define TBD_FILT_OFS 8'h0c
`define TBD_STATUS_OFS 8'h10
// ==========================================================
// Field positions and reset values
`define TBD_CTRL_EN 0
`define TBD_CTRL_MODE_LO 1
`define TBD_CTRL_AVG_LO 4
`define TBD_BUCKET_RST 4'h2
`define TBD_POINTS_RST 16'h03e9
`define TBD_LPF_RST 4'h4
`define TBD_QC_RST 4'h1
`define TBD_QD_RST 4'h8
`endif

// ---- src/tbd_detector.sv ----
/*
 Trace bucket detector with AHB-Lite register slave and output FIFO.
 Assumes one clock, samples synchronous to it, trace memory draining the FIFO.
*/
`timescale 1ns/10ps
`include "tbd_defs.svh"

// ==========================================================
// Point FIFO
module tbd_fifo #(
   parameter int W = 16,
   parameter int D = 32
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic ov;
      logic [W-1:0] od;
      logic ir;
   } tbd_fifo_t;
   tbd_fifo_t s, next_s;
   logic push, pop;

   // Output stage is a register so the top sees flop outputs only
   always_comb begin
      next_s = s;
      push = in_valid && s.ir;
      pop = (s.cnt != '0) && (!s.ov || out_ready);
      if (pop) begin
         next_s.od = s.mem[s.rp];
         next_s.ov = 1'b1;
         next_s.rp = (s.rp == AW'(D - 1)) ? '0 : s.rp + 1'b1;
      end else if (out_ready) begin
         next_s.ov = 1'b0;
      end
      if (push) begin
         next_s.mem[s.wp] = in_data;
         next_s.wp = (s.wp == AW'(D - 1)) ? '0 : s.wp + 1'b1;
      end
      next_s.cnt = s.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      next_s.ir = next_s.cnt < (AW + 1)'(D);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '{ir: 1'b1, default: '0};
      end else if (clk_en) begin
         s <= next_s;
      end
   end

   assign in_ready = s.ir;
   assign out_valid = s.ov;
   assign out_data = s.od;
endmodule : tbd_fifo

// ==========================================================
// Detector top
module tbd_detector #(
   parameter int FIFO_DEPTH = 32
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic sweep_start,
   input wire logic smp_valid,
   input wire logic [15:0] smp_lin,
   input wire logic [15:0] smp_db,
   output logic smp_ready,
   output logic pt_valid,
   output logic [15:0] pt_data,
   input wire logic pt_ready
);
   tbd_pkg::tbd_state_t s, next_s;
   logic fifo_ir, take, fin, rf;
   logic [15:0] vmx, vmn;

   // Bit-serial square root, 16 result bits
   function automatic logic [15:0] tbd_sqrt(input logic [31:0] v);
      logic [15:0] r;
      logic [15:0] t;
      r = '0;
      for (int i = 15; i >= 0; i--) begin
         t = r | (16'h0001 << i);
         if (32'(t) * 32'(t) <= v) begin
            r = t;
         end
      end
      return r;
   endfunction : tbd_sqrt

   always_comb begin
      logic [15:0] x;
      logic [16:0] len;
      logic [47:0] vacc;
      logic [47:0] mean;
      logic signed [16:0] d;
      logic [15:0] pt;
      x = smp_lin;
      len = 17'h00001 << s.blog;
      vacc = s.acc;
      mean = '0;
      d = '0;
      pt = '0;
      next_s = s;
      take = smp_valid && s.sr && !sweep_start;
      fin = 1'b0;
      vmx = s.mx;
      vmn = s.mn;
      rf = 1'b0;
      // Bus address phase; one wait state so read data comes from a flop
      if (hsel && htrans[1] && hready) begin
         next_s.ap_v = 1'b1;
         next_s.ap_w = hwrite;
         next_s.ap_a = haddr[7:0];
         next_s.rdy = 1'b0;
      end
      // Bus data phase: write or read, unmapped reads return zero
      if (s.ap_v) begin
         next_s.ap_v = 1'b0;
         next_s.rdy = 1'b1;
         next_s.rdata = '0;
         unique case (s.ap_a)
            `TBD_CTRL_OFS: begin
               next_s.rdata = {26'h0, s.avg, s.mode, s.en};
               if (s.ap_w) begin
                  next_s.en = hwdata[`TBD_CTRL_EN];
                  next_s.mode = hwdata[`TBD_CTRL_MODE_LO +: 3];
                  next_s.avg = hwdata[`TBD_CTRL_AVG_LO +: 2];
               end
            end
            `TBD_BUCKET_OFS: begin
               next_s.rdata = {28'h0, s.blog};
               if (s.ap_w) begin
                  next_s.blog = (hwdata[3:0] > 4'h8) ? 4'h8 : hwdata[3:0];
               end
            end
            `TBD_POINTS_OFS: begin
               next_s.rdata = {16'h0, s.points};
               if (s.ap_w) begin
                  next_s.points = hwdata[15:0];
               end
            end
            `TBD_FILT_OFS: begin
               next_s.rdata = {20'h0, s.qd, s.qc, s.lpf_k};
               if (s.ap_w) begin
                  next_s.lpf_k = hwdata[3:0];
                  next_s.qc = hwdata[7:4];
                  next_s.qd = hwdata[11:8];
               end
            end
            `TBD_STATUS_OFS: begin
               next_s.rdata = {14'h0, s.pv, s.run, s.bnum};
            end
            default: begin
               next_s.rdata = '0;
            end
         endcase
      end
      // Pending point leaves once the FIFO has room
      if (s.pv && fifo_ir) begin
         next_s.pv = 1'b0;
      end
      // Sweep start wins over any sample in the same cycle
      if (sweep_start) begin
         next_s.run = s.en;
         next_s.bnum = 16'h0001;
         next_s.held = '0;
         next_s.scnt = '0;
      end else if (take) begin
         vmx = (s.scnt == '0 || x > s.mx) ? x : s.mx;
         vmn = (s.scnt == '0 || x < s.mn) ? x : s.mn;
         next_s.mx = vmx;
         next_s.mn = vmn;
         if (s.scnt == '0) begin
            next_s.fst = x;
            vacc = '0;
         end
         // Only the centre sample is kept, the rest dropped
         if (17'(s.scnt) == (len >> 1)) begin
            next_s.csmp = x;
         end
         // Every sample of the bucket feeds the accumulator for the power, voltage and log types
         unique case (tbd_pkg::tbd_avg_t'(s.avg))
            tbd_pkg::TBD_POWER: vacc = vacc + 48'(32'(x) * 32'(x));
            tbd_pkg::TBD_VOLT: vacc = vacc + 48'(x);
            tbd_pkg::TBD_LOG: vacc = vacc + 48'(smp_db);
            tbd_pkg::TBD_FILT: vacc = vacc;
         endcase
         next_s.acc = vacc;
         // Narrow one-pole smoothing; shift sets bandwidth well below RESOLUTION_BANDWIDTH
         d = $signed({1'b0, x}) - $signed({1'b0, s.lpf});
         next_s.lpf = 16'($signed({1'b0, s.lpf}) + (d >>> s.lpf_k));
         // Fast charge, slow discharge: sparse impulses decay further
         if (x > s.qp) begin
            next_s.qp = s.qp + ((x - s.qp) >> s.qc);
         end else begin
            next_s.qp = s.qp - (s.qp >> s.qd);
         end
         rf = (vmx > ((s.scnt == '0) ? x : s.fst)) && (vmn < ((s.scnt == '0) ? x : s.fst));
         fin = 17'(s.scnt) == len - 17'h00001;
         next_s.scnt = fin ? '0 : s.scnt + 16'h0001;
      end
      // Bucket end: reduce to one trace point
      if (fin) begin
         mean = vacc >> s.blog;
         unique case (tbd_pkg::tbd_mode_t'(s.mode))
            tbd_pkg::TBD_SAMPLE: pt = (len == 17'h00001) ? x : next_s.csmp;
            tbd_pkg::TBD_POS: pt = vmx;
            tbd_pkg::TBD_NEG: pt = vmn;
            tbd_pkg::TBD_NORMAL: begin
               if (!rf) begin
                  pt = vmx;
               end else if (!s.bnum[0]) begin
                  pt = vmn;
                  next_s.held = vmx;
               end else begin
                  pt = (vmx > s.held) ? vmx : s.held;
                  next_s.held = '0;
               end
            end
            tbd_pkg::TBD_AVERAGE: begin
               unique case (tbd_pkg::tbd_avg_t'(s.avg))
                  tbd_pkg::TBD_POWER: pt = tbd_sqrt(mean[31:0]);
                  tbd_pkg::TBD_VOLT: pt = mean[15:0];
                  tbd_pkg::TBD_LOG: pt = mean[15:0];
                  tbd_pkg::TBD_FILT: pt = next_s.lpf;
               endcase
            end
            tbd_pkg::TBD_QPEAK: pt = next_s.qp;
            default: pt = vmx;
         endcase
         next_s.pv = 1'b1;
         next_s.pd = pt;
         next_s.bnum = s.bnum + 16'h0001;
         // Software sets bucket length from span and points minus one
         if (s.bnum >= s.points - 16'h0001) begin
            next_s.run = 1'b0;
         end
      end
      // Stall samples while a point waits, avoiding any loss
      next_s.sr = next_s.run && !next_s.pv && fifo_ir;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '{rdy: 1'b1, blog: `TBD_BUCKET_RST, points: `TBD_POINTS_RST, lpf_k: `TBD_LPF_RST,
                qc: `TBD_QC_RST, qd: `TBD_QD_RST, bnum: 16'h0001, default: '0};
      end else if (clk_en) begin
         s <= next_s;
      end
   end

   tbd_fifo #(.W(16), .D(FIFO_DEPTH)) u_fifo (
      .clk(sys_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .in_valid(s.pv),
      .in_data(s.pd),
      .in_ready(fifo_ir),
      .out_valid(pt_valid),
      .out_data(pt_data),
      .out_ready(pt_ready)
   );

   assign hreadyout = s.rdy;
   assign hresp = s.resp;
   assign hrdata = s.rdata;
   assign smp_ready = s.sr;

   // ==========================================================
   // Assertions
   a_bus_wait: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clk_en && hsel && htrans[1] && hready) |=> !hreadyout ##1 (clk_en ? hreadyout : 1'b1))
      else $error("bus wait state wrong");
   a_resp_okay: assert property (@(posedge sys_clk) disable iff (!rst_n) !hresp)
      else $error("response not okay");
   a_point_stall: assert property (@(posedge sys_clk) disable iff (!rst_n) s.pv |-> !smp_ready)
      else $error("samples taken while point pending");
   a_norm_even: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clk_en && fin && s.mode == 3'h3 && rf && !s.bnum[0]) |=> (s.pd == $past(vmn) && s.held == $past(vmx)))
      else $error("even rise-fall bucket wrong");
   a_norm_odd: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clk_en && fin && s.mode == 3'h3 && rf && s.bnum[0]) |=> (s.pd >= $past(vmx) && s.held == 16'h0))
      else $error("odd rise-fall bucket wrong");
   a_norm_mono: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clk_en && fin && s.mode == 3'h3 && !rf) |=> (s.pd == $past(vmx) && s.pv))
      else $error("monotonic bucket not maximum");
   a_peak_pos: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clk_en && fin && s.mode == 3'h1) |=> (s.pd >= $past(smp_lin) && s.pd == $past(vmx)))
      else $error("positive peak wrong");
   a_peak_neg: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clk_en && fin && s.mode == 3'h2) |=> (s.pd <= $past(smp_lin)))
      else $error("negative peak wrong");
   a_sweep_restart: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clk_en && sweep_start) |=> (s.bnum == 16'h0001 && s.held == 16'h0 && s.scnt == 16'h0))
      else $error("sweep restart wrong");
   a_sweep_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clk_en && fin && s.bnum >= s.points - 16'h0001) |=> !s.run ##1 !smp_ready)
      else $error("sweep did not stop");
   // Filter moves only toward the sample, never past it; weighted peak charges toward it, decays regardless of it
   a_lpf_track: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clk_en && take && smp_lin > s.lpf) |=> (s.lpf >= $past(s.lpf) && s.lpf <= $past(smp_lin)))
      else $error("low-pass step wrong");
   a_qp_charge: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clk_en && take && smp_lin > s.qp) |=> (s.qp >= $past(s.qp) && s.qp <= $past(smp_lin)))
      else $error("weighted peak charge wrong");
   a_qp_decay: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clk_en && take && smp_lin <= s.qp) |=> (s.qp <= $past(s.qp)))
      else $error("weighted peak decay wrong");
   a_sample_centre: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clk_en && take && 17'(s.scnt) == ((17'h00001 << s.blog) >> 1)) |=> (s.csmp == $past(smp_lin)))
      else $error("centre sample not kept");
   a_ready_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !s.run |-> !smp_ready)
      else $error("samples accepted while stopped");
endmodule : tbd_detector

// ---- src/tbd_pkg.sv ----
/*
 Types of the trace bucket detector. Assumes 16-bit amplitude samples.
*/
package tbd_pkg;
   typedef enum logic [2:0] {
      TBD_SAMPLE = 3'h0, TBD_POS = 3'h1, TBD_NEG = 3'h2,
      TBD_NORMAL = 3'h3, TBD_AVERAGE = 3'h4, TBD_QPEAK = 3'h5
   } tbd_mode_t;
   typedef enum logic [1:0] {
      TBD_POWER = 2'h0, TBD_VOLT = 2'h1, TBD_LOG = 2'h2, TBD_FILT = 2'h3
   } tbd_avg_t;
   typedef struct packed {
      logic ap_v;
      logic ap_w;
      logic [7:0] ap_a;
      logic rdy;
      logic resp;
      logic [31:0] rdata;
      logic en;
      logic [2:0] mode;
      logic [1:0] avg;
      logic [3:0] blog;
      logic [15:0] points;
      logic [3:0] lpf_k;
      logic [3:0] qc;
      logic [3:0] qd;
      logic run;
      logic [15:0] bnum;
      logic [15:0] scnt;
      logic [15:0] fst;
      logic [15:0] mx;
      logic [15:0] mn;
      logic [15:0] held;
      logic [15:0] csmp;
      logic [47:0] acc;
      logic [15:0] lpf;
      logic [15:0] qp;
      logic pv;
      logic [15:0] pd;
      logic sr;
   } tbd_state_t;
endpackage : tbd_pkg

// ---- test/tbd_detector_tb_top.sv ----
/*
 Self-checking bench: register bus tasks, one task per detector scenario.
 Assumes tbd_partner feeds samples and takes points; clk_en tied high.
*/
`timescale 1ns/10ps
`include "tbd_defs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
   $display("unexpected at %0t: got %h exp %h", $time, g, e); end end

// ==========================================================
// Bench top
module tbd_detector_tb_top;
   logic sys_clk, rst_n, hsel, hwrite, hreadyout, hresp, sweep_start, smp_valid, smp_ready;
   logic pt_valid, pt_ready, stall;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [15:0] smp_lin, smp_db, pt_data;
   logic [15:0] din_q[$], exp_q[$];
   int n_fail = 0;
   int compares = 0;

   tbd_detector #(.FIFO_DEPTH(32)) tbd_detector_i (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .sweep_start(sweep_start), .smp_valid(smp_valid), .smp_lin(smp_lin), .smp_db(smp_db),
      .smp_ready(smp_ready), .pt_valid(pt_valid), .pt_data(pt_data), .pt_ready(pt_ready));

   tbd_partner tbd_partner_i (.clk(sys_clk), .stall(stall), .smp_ready(smp_ready), .smp_valid(smp_valid),
      .smp_lin(smp_lin), .smp_db(smp_db), .pt_valid(pt_valid), .pt_data(pt_data), .pt_ready(pt_ready));

   // 100 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // ==========================================================
   // Closing report and bus tasks
   task end_of_test;
      if (n_fail == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_of_test

   // Bounded wait for hready; a hang ends the run as a failure
   task wait_rdy;
      int i;
      i = 0;
      do begin
         @(posedge sys_clk);
         i++;
      end while (hreadyout !== 1'b1 && i < 50);
      if (i >= 50) begin
         n_fail++;
         end_of_test;
      end
   endtask : wait_rdy

   // One single word transfer; read data lands in rd
   task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= w;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy;
      rd = hrdata;
   endtask : bus

   // Program, start one sweep, feed din_q and judge the points against exp_q
   task sweep(input logic [2:0] mode, input logic [1:0] avg, input logic [3:0] blog, input logic [15:0] pts);
      int i;
      tbd_partner_i.pt_q.delete();
      bus(1'b1, `TBD_BUCKET_OFS, {28'h0000000, blog});
      bus(1'b1, `TBD_POINTS_OFS, {16'h0000, pts});
      bus(1'b1, `TBD_CTRL_OFS, {26'h0000000, avg, mode, 1'b1});
      sweep_start <= 1'b1;
      @(posedge sys_clk);
      sweep_start <= 1'b0;
      tbd_partner_i.src_q = din_q;
      i = 0;
      while (tbd_partner_i.pt_q.size() < exp_q.size() && i < 3000) begin
         @(posedge sys_clk);
         i++;
      end
      if (i >= 3000) begin
         n_fail++;
         end_of_test;
      end
      // Idle window shows that no extra point follows the last bucket
      repeat (20) @(posedge sys_clk);
      tbd_partner_i.src_q.delete();
      `CHK(tbd_partner_i.pt_q.size(), exp_q.size()) // Point count
      `CHK(smp_ready, 1'b0) // Stopped at sweep end
      `CHK(pt_valid, 1'b0) // Fully drained
      foreach (exp_q[k]) `CHK(tbd_partner_i.pt_q[k], exp_q[k]) // Values
   endtask : sweep

   // ==========================================================
   // Scenarios
   task t_regs;
      `CHK(smp_ready, 1'b0) // Idle before sweep
      `CHK(pt_valid, 1'b0) // No point before sweep
      bus(1'b0, `TBD_BUCKET_OFS, 32'h0);
      `CHK(rd, {28'h0000000, `TBD_BUCKET_RST}) // Reset length
      bus(1'b0, `TBD_POINTS_OFS, 32'h0);
      `CHK(rd, {16'h0000, `TBD_POINTS_RST}) // Reset points
      bus(1'b0, `TBD_FILT_OFS, 32'h0);
      `CHK(rd, {20'h00000, `TBD_QD_RST, `TBD_QC_RST, `TBD_LPF_RST}) // Filter reset
      bus(1'b1, 8'h20, 32'hffffffff);
      bus(1'b0, 8'h20, 32'h0);
      `CHK(rd, 32'h00000000) // Unmapped reads zero
      bus(1'b1, `TBD_CTRL_OFS, 32'h0000002a);
      bus(1'b0, `TBD_CTRL_OFS, 32'h0);
      `CHK(rd, 32'h0000002a) // Mode and type read back
   endtask : t_regs

   // Smoothing from its reset state, weighted peak from the state the first sweep leaves, constant input
   task t_filt;
      din_q = '{16'h100, 16'h100};
      exp_q = '{16'h10, 16'h1f};
      sweep(3'h4, 2'h3, 4'h0, 16'h3); // Low-pass steps
      exp_q = '{16'he0, 16'hf0};
      sweep(3'h5, 2'h0, 4'h0, 16'h3); // Charge toward peak
   endtask : t_filt

   // Same buckets through every detector but weighted peak, with voltage and log averaging
   task t_detect;
      din_q = '{16'h5, 16'h9, 16'h8, 16'h2, 16'h4, 16'h8, 16'h3, 16'h1, 16'h2, 16'h6, 16'h4, 16'h0};
      exp_q = '{16'h8, 16'h3, 16'h4};
      sweep(3'h0, 2'h0, 4'h2, 16'h4); // Centre pick
      exp_q = '{16'h9, 16'h8, 16'h6};
      sweep(3'h1, 2'h0, 4'h2, 16'h4); // Maximum
      sweep(3'h6, 2'h0, 4'h2, 16'h4); // Spare code as maximum
      sweep(3'h7, 2'h0, 4'h2, 16'h4); // Spare code as maximum
      exp_q = '{16'h2, 16'h1, 16'h0};
      sweep(3'h2, 2'h0, 4'h2, 16'h4); // Minimum
      exp_q = '{16'h9, 16'h1, 16'h8};
      sweep(3'h3, 2'h0, 4'h2, 16'h4); // Rise and fall parity
      exp_q = '{16'h6, 16'h4, 16'h3};
      sweep(3'h4, 2'h1, 4'h2, 16'h4); // Linear mean
      exp_q = '{16'h106, 16'h104, 16'h103};
      sweep(3'h4, 2'h2, 4'h2, 16'h4); // Log mean
   endtask : t_detect

   // Monotonic and flat buckets, then root mean square
   task t_other;
      din_q = '{16'h1, 16'h2, 16'h3, 16'h4, 16'h9, 16'h7, 16'h5, 16'h3, 16'h2, 16'h2, 16'h2, 16'h2};
      exp_q = '{16'h4, 16'h9, 16'h2};
      sweep(3'h3, 2'h0, 4'h2, 16'h4); // One-way buckets
      din_q = '{16'h3, 16'h3, 16'h3, 16'h3, 16'h1, 16'h1, 16'h7, 16'h7, 16'h0, 16'h0, 16'h0, 16'h0};
      exp_q = '{16'h3, 16'h5, 16'h0};
      sweep(3'h4, 2'h0, 4'h2, 16'h4); // Power type
   endtask : t_other

   // Maximum kept by an even bucket must not leak into the next sweep
   task t_restart;
      din_q = '{16'h5, 16'h9, 16'h8, 16'h2, 16'h4, 16'h8, 16'h3, 16'h1};
      exp_q = '{16'h9, 16'h1};
      sweep(3'h3, 2'h0, 4'h2, 16'h3); // Even bucket keeps maximum
      din_q = '{16'h2, 16'h6, 16'h4, 16'h0, 16'h5, 16'h9, 16'h8, 16'h2};
      exp_q = '{16'h6, 16'h2};
      sweep(3'h3, 2'h0, 4'h2, 16'h3); // Fresh numbering and memory
   endtask : t_restart

   // Trace memory stalls until the point buffer refuses, then drains it
   task t_fifo;
      din_q.delete();
      for (int k = 1; k < 40; k++) begin
         din_q.push_back(16'(k));
      end
      exp_q = din_q;
      stall <= 1'b1;
      fork
         begin
            repeat (300) @(posedge sys_clk);
            `CHK(smp_ready, 1'b0) // Source held off while full
            `CHK(tbd_partner_i.src_q.size() > 0, 1'b1) // Samples left waiting
            `CHK(pt_valid, 1'b1) // Point stands while stalled
            stall <= 1'b0;
         end
      join_none
      sweep(3'h1, 2'h0, 4'h0, 16'h28); // Order kept through buffer
   endtask : t_fifo

   // Reset, then the scenarios in turn
   initial begin
      rst_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      sweep_start = 1'b0;
      stall = 1'b0;
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      t_regs;
      t_filt;
      t_detect;
      t_other;
      t_restart;
      t_fifo;
      end_of_test;
   end
endmodule : tbd_detector_tb_top

// ---- test/tbd_partner.sv ----
/*
 Far-side model: envelope sample source and trace memory sink.
 Assumes the bench loads src_q after a sweep start, reads pt_q and drives stall.
*/
`timescale 1ns/10ps

// ==========================================================
// Sample source and trace memory
module tbd_partner (
   input wire logic clk,
   input wire logic stall,
   input wire logic smp_ready,
   output logic smp_valid,
   output logic [15:0] smp_lin,
   output logic [15:0] smp_db,
   input wire logic pt_valid,
   input wire logic [15:0] pt_data,
   output logic pt_ready
);
   logic [15:0] src_q[$];
   logic [15:0] pt_q[$];

   // Valid and ready low, data at zero, until the first clock edge
   initial begin
      smp_valid = 1'b0;
      smp_lin = 16'h0;
      smp_db = 16'h0;
      pt_ready = 1'b0;
   end

   // Head of queue stands until taken; dB value is offset so log and linear differ
   always @(posedge clk) begin
      if (smp_valid && smp_ready) begin
         void'(src_q.pop_front());
      end
      if (src_q.size() > 0) begin
         smp_valid <= 1'b1;
         smp_lin <= src_q[0];
         smp_db <= src_q[0] + 16'h0100;
      end else begin
         // Idle lines toggle so a stale value is never taken for a fresh one
         smp_valid <= 1'b0;
         smp_lin <= ~smp_lin;
         smp_db <= ~smp_db;
      end
   end

   // Trace memory stores each accepted point; stall holds ready low
   always @(posedge clk) begin
      if (pt_valid && pt_ready) begin
         pt_q.push_back(pt_data);
      end
      pt_ready <= !stall;
   end
endmodule : tbd_partner
